// >>> hdl/amp_param_bank.sv
/*
 * per-axis motion parameter bank: execution registers with a two-stage queue each,
 * apb slave access, start handling and small derived values for the pulse generator.
 * assumes the pulse generator sits on core_clk, samples the execution copies while
 * run_start is high, and pulses op_done when a move completes.
 */
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module amp_param_bank #(
	parameter int ADDR_W = 8
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic op_done,
	input wire logic [27:0] remaining_pulses,
	output logic run_start,
	output logic running,
	output logic [27:0] target_increment,
	output logic [15:0] start_speed,
	output logic [15:0] operating_speed,
	output logic [15:0] accel_rate,
	output logic [15:0] decel_rate,
	output logic [11:0] speed_scale,
	output logic [23:0] ramp_down_point,
	output logic [31:0] operation_mode_word,
	output logic [6:0] operation_code,
	output logic ramp_point_manual_sel,
	output logic [15:0] decel_rate_eff,
	output logic [12:0] scale_divisor,
	output logic ramp_decel_req
);
	localparam int N = amp_pkg::NUM_REGS;

	if (ADDR_W < 8) begin
		$error("amp_param_bank needs at least 8 address bits");
	end

	typedef struct packed {
		logic [N-1:0][31:0] ex;
		logic [N-1:0][31:0] q1;
		logic [N-1:0][31:0] q2;
		logic [N-1:0] exf;
		logic [N-1:0] q1v;
		logic [N-1:0] q2v;
		logic running;
		logic start;
		logic ack;
		logic [31:0] rdata;
		logic slverr;
		logic [15:0] decel_eff;
		logic [12:0] scale_div;
		logic ramp_req;
	} amp_state_t;

	amp_state_t s_r;
	amp_state_t s_nxt;

	function automatic logic [31:0] amp_mask(input int i);
		case (i)
			amp_pkg::IDX_TARGET: amp_mask = amp_pkg::MASK_TARGET;
			amp_pkg::IDX_START_SPEED: amp_mask = amp_pkg::MASK_SPEED16;
			amp_pkg::IDX_OPER_SPEED: amp_mask = amp_pkg::MASK_SPEED16;
			amp_pkg::IDX_ACCEL: amp_mask = amp_pkg::MASK_SPEED16;
			amp_pkg::IDX_DECEL: amp_mask = amp_pkg::MASK_SPEED16;
			amp_pkg::IDX_SCALE: amp_mask = amp_pkg::MASK_SCALE;
			amp_pkg::IDX_RAMP: amp_mask = amp_pkg::MASK_RAMP;
			default: amp_mask = amp_pkg::MASK_MODE;
		endcase
	endfunction

	// stored values are already masked; target and auto-mode ramp reads sign extend, other unused bits read zero
	function automatic logic [31:0] amp_fmt(input int i, input logic [31:0] v, input logic manual);
		case (i)
			amp_pkg::IDX_TARGET: amp_fmt = {{4{v[amp_pkg::TARGET_MSB]}}, v[27:0]};
			amp_pkg::IDX_RAMP: amp_fmt = manual ? {8'h00, v[23:0]} :
				{{8{v[amp_pkg::RAMP_MSB]}}, v[23:0]};
			default: amp_fmt = v;
		endcase
	endfunction

	logic hit_exec;
	logic hit_queue;
	logic hit_ctrl;
	logic hit_stat;
	logic [2:0] sel;
	logic acc;
	logic wr_acc;
	logic [31:0] wdata_b;
	logic manual;

	assign sel = paddr[4:2];
	assign hit_exec = (paddr[7:5] == amp_pkg::OFS_EXEC_BASE[7:5]) && (paddr[1:0] == 2'b00);
	assign hit_queue = (paddr[7:5] == amp_pkg::OFS_QUEUE_BASE[7:5]) && (paddr[1:0] == 2'b00);
	assign hit_ctrl = (paddr[7:0] == amp_pkg::OFS_CONTROL);
	assign hit_stat = (paddr[7:0] == amp_pkg::OFS_STATUS);
	assign acc = psel && penable && s_r.ack;
	assign wr_acc = acc && pwrite && !s_r.slverr;
	assign manual = s_r.ex[amp_pkg::IDX_MODE][amp_pkg::MODE_RAMP_SEL_BIT];

	// byte lanes without a strobe keep the written register's old bits
	always_comb begin
		logic [31:0] base;
		base = hit_exec ? s_r.ex[sel] : s_r.q2[sel];
		for (int b = 0; b < 4; b++) begin
			wdata_b[b*8 +: 8] = pstrb[b] ? pwdata[b*8 +: 8] : base[b*8 +: 8];
		end
	end

	always_comb begin
		logic start_now;
		logic [15:0] dec;
		start_now = 1'b0;
		dec = 16'h0000;
		s_nxt = s_r;
		// apb: one wait state, answer prepared in the first access cycle
		if (psel && penable && !s_r.ack) begin
			s_nxt.ack = 1'b1;
			s_nxt.slverr = !(hit_exec || hit_queue || hit_ctrl || hit_stat) ||
				(ADDR_W > 8 && |paddr[ADDR_W-1:ADDR_W > 8 ? 8 : ADDR_W-1]);
			s_nxt.rdata = 32'h0000_0000;
			if (hit_exec) begin
				s_nxt.rdata = amp_fmt(int'(sel), s_r.ex[sel], manual);
			end else if (hit_queue) begin
				s_nxt.rdata = amp_fmt(int'(sel), s_r.q2[sel], manual);
			end else if (hit_stat) begin
				s_nxt.rdata = {7'h00, s_r.running, s_r.exf, s_r.q1v, s_r.q2v};
			end
		end else begin
			s_nxt.ack = 1'b0;
		end
		if (wr_acc && hit_ctrl && pstrb[0] && pwdata[amp_pkg::CTRL_START_BIT]) begin
			start_now = 1'b1;
		end
		s_nxt.start = start_now;
		// start wins over a completion in the same cycle
		if (start_now) begin
			s_nxt.running = 1'b1;
		end else if (op_done) begin
			s_nxt.running = 1'b0;
		end
		for (int i = 0; i < N; i++) begin
			// launched data leaves the execution stage
			if (s_r.start) begin
				s_nxt.exf[i] = 1'b0;
			end
			// forward whenever the stage ahead is empty
			if (!s_r.exf[i] && s_r.q1v[i]) begin
				s_nxt.ex[i] = s_r.q1[i];
				s_nxt.exf[i] = 1'b1;
				s_nxt.q1v[i] = 1'b0;
			end
			if ((!s_r.q1v[i] || (!s_r.exf[i] && s_r.q1v[i])) && s_r.q2v[i]) begin
				s_nxt.q1[i] = s_r.q2[i];
				s_nxt.q1v[i] = 1'b1;
				s_nxt.q2v[i] = 1'b0;
			end
			// queue write, overwrites stage two when both stages and the execution stage are full
			if (wr_acc && hit_queue && int'(sel) == i) begin
				s_nxt.q2[i] = wdata_b & amp_mask(i);
				s_nxt.q2v[i] = 1'b1;
			end
			// direct write takes effect at once, also during a move
			if (wr_acc && hit_exec && int'(sel) == i) begin
				s_nxt.ex[i] = wdata_b & amp_mask(i);
				s_nxt.exf[i] = 1'b1;
			end
		end
		dec = s_r.ex[amp_pkg::IDX_DECEL][15:0];
		s_nxt.decel_eff = (dec == 16'h0000) ? s_r.ex[amp_pkg::IDX_ACCEL][15:0] : dec;
		// divisor of the reference clock per 65536 counts
		s_nxt.scale_div = {1'b0, s_r.ex[amp_pkg::IDX_SCALE][11:0]} + 13'h0001;
		// manual ramp point compares remaining pulses with the unsigned value
		s_nxt.ramp_req = manual && s_r.running &&
			({4'h0, remaining_pulses} < {8'h00, s_r.ex[amp_pkg::IDX_RAMP][23:0]});
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s_r <= '0;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	assign prdata = s_r.rdata;
	assign pready = s_r.ack;
	assign pslverr = s_r.ack && s_r.slverr;
	assign run_start = s_r.start;
	assign running = s_r.running;
	assign target_increment = s_r.ex[amp_pkg::IDX_TARGET][27:0];
	assign start_speed = s_r.ex[amp_pkg::IDX_START_SPEED][15:0];
	assign operating_speed = s_r.ex[amp_pkg::IDX_OPER_SPEED][15:0];
	assign accel_rate = s_r.ex[amp_pkg::IDX_ACCEL][15:0];
	assign decel_rate = s_r.ex[amp_pkg::IDX_DECEL][15:0];
	assign speed_scale = s_r.ex[amp_pkg::IDX_SCALE][11:0];
	assign ramp_down_point = s_r.ex[amp_pkg::IDX_RAMP][23:0];
	assign operation_mode_word = s_r.ex[amp_pkg::IDX_MODE];
	assign operation_code = s_r.ex[amp_pkg::IDX_MODE][6:0];
	assign ramp_point_manual_sel = manual;
	assign decel_rate_eff = s_r.decel_eff;
	assign scale_divisor = s_r.scale_div;
	assign ramp_decel_req = s_r.ramp_req;

	property p_reset_clear;
		@(posedge core_clk) !rst_n |=> (s_r.ex == '0) && (s_r.q1 == '0) && (s_r.q2 == '0);
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("bank not cleared by reset");

	property p_target_signext;
		@(posedge core_clk) disable iff (!rst_n)
		(ce && psel && penable && !s_r.ack && !pwrite && hit_exec && sel == 3'd0)
		|=> prdata[31:28] == {4{prdata[27]}};
	endproperty
	a_target_signext: assert property (p_target_signext) else $error("target read not sign extended");

	property p_unused_zero;
		@(posedge core_clk) disable iff (!rst_n)
		(ce && psel && penable && !s_r.ack && !pwrite && hit_exec && sel == 3'd3)
		|=> prdata[31:16] == 16'h0000;
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("unused accel bits not zero");

	property p_decel_fallback;
		@(posedge core_clk) disable iff (!rst_n)
		(ce && decel_rate == 16'h0000) |=> decel_rate_eff == $past(accel_rate);
	endproperty
	a_decel_fallback: assert property (p_decel_fallback) else $error("zero decel did not use accel");

	property p_scale_div;
		@(posedge core_clk) disable iff (!rst_n)
		ce |=> scale_divisor == {1'b0, $past(speed_scale)} + 13'h0001;
	endproperty
	a_scale_div: assert property (p_scale_div) else $error("scale divisor wrong");

	property p_ramp_manual;
		@(posedge core_clk) disable iff (!rst_n)
		(ce && ramp_point_manual_sel && running && remaining_pulses[27:24] == 4'h0 &&
		remaining_pulses[23:0] < ramp_down_point) |=> ramp_decel_req;
	endproperty
	a_ramp_manual: assert property (p_ramp_manual) else $error("manual ramp point missed");

	property p_mode_zero;
		@(posedge core_clk) disable iff (!rst_n)
		operation_mode_word[7] == 1'b0 && operation_mode_word[31:28] == 4'h0;
	endproperty
	a_mode_zero: assert property (p_mode_zero) else $error("reserved mode bits set");

	property p_start_advance;
		@(posedge core_clk) disable iff (!rst_n)
		(ce && run_start && s_r.q1v[0] && !(wr_acc && hit_exec)) ##1 (ce && !(wr_acc && hit_exec))
		|=> target_increment == $past(s_r.q1[0][27:0], 2);
	endproperty
	a_start_advance: assert property (p_start_advance) else $error("queue did not advance after start");

	property p_queue_write;
		@(posedge core_clk) disable iff (!rst_n)
		(ce && wr_acc && hit_queue && sel == 3'd0 && pstrb == 4'hF)
		|=> s_r.q2v[0] && s_r.q2[0] == ($past(pwdata) & amp_pkg::MASK_TARGET);
	endproperty
	a_queue_write: assert property (p_queue_write) else $error("queue write lost");

	property p_fifo_fwd;
		@(posedge core_clk) disable iff (!rst_n)
		(ce && s_r.q2v[0] && !s_r.q1v[0]) |=> s_r.q1v[0] && s_r.q1[0] == $past(s_r.q2[0]);
	endproperty
	a_fifo_fwd: assert property (p_fifo_fwd) else $error("queue stage did not move forward");

	property p_override;
		@(posedge core_clk) disable iff (!rst_n)
		(ce && wr_acc && hit_exec && sel == 3'd0 && pstrb == 4'hF)
		|=> target_increment == $past(pwdata[27:0]);
	endproperty
	a_override: assert property (p_override) else $error("target override not applied");

	property p_decel_direct;
		@(posedge core_clk) disable iff (!rst_n)
		(ce && decel_rate != 16'h0000) |=> decel_rate_eff == $past(decel_rate);
	endproperty
	a_decel_direct: assert property (p_decel_direct) else $error("nonzero decel not used");

	property p_speed_unused;
		@(posedge core_clk) disable iff (!rst_n)
		(ce && psel && penable && !s_r.ack && !pwrite && hit_exec && sel == 3'd1)
		|=> prdata[31:16] == 16'h0000;
	endproperty
	a_speed_unused: assert property (p_speed_unused) else $error("unused start speed bits not zero");

	property p_scale_unused;
		@(posedge core_clk) disable iff (!rst_n)
		(ce && psel && penable && !s_r.ack && !pwrite && hit_exec && sel == 3'd5)
		|=> prdata[31:12] == 20'h0_0000;
	endproperty
	a_scale_unused: assert property (p_scale_unused) else $error("unused scale bits not zero");

	property p_ramp_auto_read;
		@(posedge core_clk) disable iff (!rst_n)
		(ce && psel && penable && !s_r.ack && !pwrite && hit_exec && sel == 3'd6 && !ramp_point_manual_sel)
		|=> prdata[31:24] == {8{prdata[23]}};
	endproperty
	a_ramp_auto_read: assert property (p_ramp_auto_read) else $error("auto ramp read not sign extended");

	property p_ramp_manual_read;
		@(posedge core_clk) disable iff (!rst_n)
		(ce && psel && penable && !s_r.ack && !pwrite && hit_exec && sel == 3'd6 && ramp_point_manual_sel)
		|=> prdata[31:24] == 8'h00;
	endproperty
	a_ramp_manual_read: assert property (p_ramp_manual_read) else $error("manual ramp upper bits not zero");

	property p_mode_read;
		@(posedge core_clk) disable iff (!rst_n)
		(ce && psel && penable && !s_r.ack && !pwrite && hit_exec && sel == 3'd7)
		|=> prdata[7] == 1'b0 && prdata[31:28] == 4'h0;
	endproperty
	a_mode_read: assert property (p_mode_read) else $error("reserved mode bits read nonzero");

	property p_queue_read;
		@(posedge core_clk) disable iff (!rst_n)
		(ce && psel && penable && !s_r.ack && !pwrite && hit_queue && sel == 3'd0)
		|=> prdata[27:0] == $past(s_r.q2[0][27:0]);
	endproperty
	a_queue_read: assert property (p_queue_read) else $error("queue read wrong");

	property p_queue_signext;
		@(posedge core_clk) disable iff (!rst_n)
		(ce && psel && penable && !s_r.ack && !pwrite && hit_queue && sel == 3'd0)
		|=> prdata[31:28] == {4{prdata[27]}};
	endproperty
	a_queue_signext: assert property (p_queue_signext) else $error("queued target not sign extended");

	property p_ramp_auto_idle;
		@(posedge core_clk) disable iff (!rst_n)
		(ce && !ramp_point_manual_sel) |=> !ramp_decel_req;
	endproperty
	a_ramp_auto_idle: assert property (p_ramp_auto_idle) else $error("ramp request in auto mode");

	property p_fifo_exec;
		@(posedge core_clk) disable iff (!rst_n)
		(ce && !s_r.exf[0] && s_r.q1v[0] && !(wr_acc && hit_exec))
		|=> s_r.exf[0] && target_increment == $past(s_r.q1[0][27:0]);
	endproperty
	a_fifo_exec: assert property (p_fifo_exec) else $error("queue stage did not reach execution");
endmodule

// >>> pkg/amp_pkg.sv
/*
 * constants for the per-axis motion parameter bank: register indices, apb offsets,
 * field masks, control and status bit positions.
 * assumes a 32-bit apb slave with word-aligned byte addresses.
 */
package amp_pkg;
	localparam int NUM_REGS = 8;
	localparam int IDX_TARGET = 0;
	localparam int IDX_START_SPEED = 1;
	localparam int IDX_OPER_SPEED = 2;
	localparam int IDX_ACCEL = 3;
	localparam int IDX_DECEL = 4;
	localparam int IDX_SCALE = 5;
	localparam int IDX_RAMP = 6;
	localparam int IDX_MODE = 7;

	localparam logic [7:0] OFS_EXEC_BASE = 8'h00;
	localparam logic [7:0] OFS_QUEUE_BASE = 8'h20;
	localparam logic [7:0] OFS_CONTROL = 8'h40;
	localparam logic [7:0] OFS_STATUS = 8'h44;

	localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
	localparam logic [31:0] MASK_TARGET = 32'h0FFF_FFFF;
	localparam logic [31:0] MASK_SPEED16 = 32'h0000_FFFF;
	localparam logic [31:0] MASK_SCALE = 32'h0000_0FFF;
	localparam logic [31:0] MASK_RAMP = 32'h00FF_FFFF;
	localparam logic [31:0] MASK_MODE = 32'h0FFF_FF7F;

	localparam int TARGET_MSB = 27;
	localparam int RAMP_MSB = 23;
	localparam int MODE_RAMP_SEL_BIT = 13;
	localparam int CTRL_START_BIT = 0;
	localparam int STAT_RUNNING_BIT = 24;
endpackage

// >>> test/axis_motion_param_registers_tb.sv
/* bench for the motion parameter bank: apb access, masks, queue stages, start and derived outputs.
 * assumes amp_pkg is compiled first; drives every port of amp_param_bank itself. */
`timescale 1ns/1ps
module axis_motion_param_registers_tb;
	logic core_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, op_done = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'hF;
	logic [27:0] remaining_pulses = 28'h000_0000;
	logic [31:0] prdata, operation_mode_word, r, d;
	logic [31:0] w_m [8];
	logic pready, pslverr, run_start, running, ramp_point_manual_sel, ramp_decel_req, e;
	logic [27:0] target_increment;
	logic [15:0] start_speed, operating_speed, accel_rate, decel_rate, decel_rate_eff;
	logic [11:0] speed_scale;
	logic [23:0] ramp_down_point;
	logic [6:0] operation_code;
	logic [12:0] scale_divisor;
	int mismatches = 0, checks = 0, i;
	amp_param_bank #(.ADDR_W(8)) i_amp_param_bank (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .op_done(op_done), .remaining_pulses(remaining_pulses),
		.run_start(run_start), .running(running), .target_increment(target_increment), .start_speed(start_speed),
		.operating_speed(operating_speed), .accel_rate(accel_rate), .decel_rate(decel_rate),
		.speed_scale(speed_scale), .ramp_down_point(ramp_down_point), .operation_mode_word(operation_mode_word),
		.operation_code(operation_code), .ramp_point_manual_sel(ramp_point_manual_sel),
		.decel_rate_eff(decel_rate_eff), .scale_divisor(scale_divisor), .ramp_decel_req(ramp_decel_req));
	always #50 core_clk = ~core_clk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat, input logic [3:0] s);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= dat;
		pstrb <= s;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic [31:0] expv(input int k, input logic [31:0] v, input logic man);
		logic [31:0] m;
		case (k)
			0: m = {{4{v[27]}}, v[27:0]};
			5: m = v & amp_pkg::MASK_SCALE;
			6: m = man ? (v & amp_pkg::MASK_RAMP) : {{8{v[23]}}, v[23:0]};
			7: m = v & amp_pkg::MASK_MODE;
			default: m = v & amp_pkg::MASK_SPEED16;
		endcase
		return m;
	endfunction
	task automatic wr(input int k, input logic [31:0] v);
		apb(1'b1, 8'(k * 4), v, 4'hF);
		w_m[k] = v;
	endtask
	task automatic rd_all();
		for (int k = 0; k < 8; k++) begin
			apb(1'b0, 8'(k * 4), 32'h0000_0000, 4'hF);
			chk(r, expv(k, w_m[k], w_m[7][13]));
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge core_clk);
		mismatches++;
		conclude();
	end
	initial begin
		void'($urandom(90));
		w_m = '{default: 32'h0000_0000};
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		@(negedge core_clk);
		chk({1'b0, pready, running, run_start, target_increment}, 32'h0000_0000);
		rd_all();
		for (int k = 0; k < 8; k++) begin
			apb(1'b0, amp_pkg::OFS_QUEUE_BASE + 8'(k * 4), 32'h0000_0000, 4'hF);
			chk(r, 32'h0000_0000);
		end
		$display("test reset done");
		for (int k = 0; k < 40; k++) begin
			i = (k < 8) ? k : int'($urandom % 8);
			d = (k < 8) ? 32'hFFFF_FFFF : $urandom;
			wr(i, d);
			if (k % 4 == 3) rd_all();
		end
		chk({4'h0, target_increment}, {4'h0, w_m[0][27:0]});
		for (int m = 0; m < 2; m++) begin
			wr(7, m ? 32'h0000_2000 : 32'h0000_0000);
			wr(6, 32'h0080_0000);
			rd_all();
		end
		$display("test masks done");
		wr(4, 32'h0000_0000);
		wr(3, $urandom);
		repeat (2) @(negedge core_clk);
		chk({16'h0000, decel_rate_eff}, {16'h0000, w_m[3][15:0]});
		chk({19'h0_0000, scale_divisor}, {19'h0_0000, 13'(w_m[5][11:0]) + 13'h0001});
		wr(0, 32'h0FFF_FFFF);
		apb(1'b1, 8'h00, 32'h0000_0000, 4'h1);
		w_m[0] = 32'h0FFF_FF00;
		rd_all();
		for (int k = 0; k < 2; k++) begin
			apb(1'b0, k ? 8'h02 : 8'h48, 32'h0000_0000, 4'hF);
			chk({31'h0000_0000, e}, 32'h0000_0001);
			chk(r, 32'h0000_0000);
		end
		$display("test derived and refusals done");
		for (int k = 1; k < 6; k++) begin
			wr(k, 32'h0000_0100);
		end
		wr(7, 32'h0000_2000);
		wr(6, 32'h0000_0064);
		remaining_pulses <= 28'h000_0032;
		apb(1'b1, amp_pkg::OFS_CONTROL, 32'h0000_0001, 4'hF);
		@(negedge core_clk);
		chk({30'h0000_0000, run_start, running}, 32'h0000_0003);
		repeat (3) @(negedge core_clk);
		chk({31'h0000_0000, ramp_decel_req}, 32'h0000_0001);
		@(posedge core_clk);
		remaining_pulses <= 28'h000_00C8;
		repeat (3) @(negedge core_clk);
		chk({31'h0000_0000, ramp_decel_req}, 32'h0000_0000);
		wr(0, 32'h0000_1234);
		@(negedge core_clk);
		chk({4'h0, target_increment}, 32'h0000_1234);
		@(posedge core_clk);
		op_done <= 1'b1;
		@(posedge core_clk);
		op_done <= 1'b0;
		@(negedge core_clk);
		chk({31'h0000_0000, running}, 32'h0000_0000);
		$display("test start and ramp done");
		wr(0, 32'h0000_0111);
		apb(1'b1, amp_pkg::OFS_QUEUE_BASE, 32'h0000_0AAA, 4'hF);
		apb(1'b1, amp_pkg::OFS_QUEUE_BASE, 32'h0000_0BBB, 4'hF);
		apb(1'b1, amp_pkg::OFS_QUEUE_BASE, 32'h0000_0CCC, 4'hF);
		apb(1'b0, amp_pkg::OFS_QUEUE_BASE, 32'h0000_0000, 4'hF);
		chk(r, 32'h0000_0CCC);
		apb(1'b0, amp_pkg::OFS_STATUS, 32'h0000_0000, 4'hF);
		chk(r & 32'h0001_0101, 32'h0001_0101);
		chk({4'h0, target_increment}, 32'h0000_0111);
		apb(1'b1, amp_pkg::OFS_CONTROL, 32'h0000_0001, 4'hF);
		@(negedge core_clk);
		chk({4'h0, target_increment}, 32'h0000_0111);
		repeat (2) @(negedge core_clk);
		chk({4'h0, target_increment}, 32'h0000_0AAA);
		apb(1'b1, amp_pkg::OFS_CONTROL, 32'h0000_0001, 4'hF);
		repeat (3) @(negedge core_clk);
		chk({4'h0, target_increment}, 32'h0000_0CCC);
		apb(1'b0, amp_pkg::OFS_STATUS, 32'h0000_0000, 4'hF);
		chk(r & 32'h0000_0101, 32'h0000_0000);
		$display("test queue done");
		@(posedge core_clk);
		ce <= 1'b0;
		op_done <= 1'b1;
		@(posedge core_clk);
		ce <= 1'b1;
		op_done <= 1'b0;
		@(negedge core_clk);
		chk({31'h0000_0000, running}, 32'h0000_0001);
		apb(1'b1, amp_pkg::OFS_QUEUE_BASE + 8'h04, 32'h0000_0055, 4'hF);
		@(posedge core_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		w_m = '{default: 32'h0000_0000};
		@(negedge core_clk);
		chk({1'b0, pready, running, run_start, target_increment}, 32'h0000_0000);
		rd_all();
		apb(1'b0, amp_pkg::OFS_STATUS, 32'h0000_0000, 4'hF);
		chk(r, 32'h0000_0000);
		$display("test clock enable and reset done");
		conclude();
	end
endmodule
